// file: mua_frame.sv
// Serial frame engine: one clause 22 read or write on the management pins.
`timescale 1ns/10ps
module mua_frame #(
    parameter int HALF_CYC = mua_pkg::MDC_HALF_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic        is_write,
    input  wire logic [4:0]  phy,
    input  wire logic [4:0]  regi,
    input  wire logic [15:0] wdata,
    input  wire logic        mdio_in,
    output logic             busy,
    output logic             done,
    output logic             ack,
    output logic      [15:0] rdata,
    output logic             mdc,
    output logic             mdio_o,
    output logic             mdio_oe_n
);
    localparam int CW = $clog2(HALF_CYC + 1);
    localparam logic [CW-1:0] DIV_END = CW'(HALF_CYC - 1);

    typedef struct packed {
        mua_pkg::mua_fstate_e st;
        logic [CW-1:0]        div;
        logic [6:0]           cnt;
        logic [63:0]          sh;
        logic                 rd;
        logic                 mdc;
        logic                 oe_n;
        logic                 ack;
        logic [15:0]          rdata;
        logic                 done;
    } mua_frame_s;

    mua_frame_s r;
    mua_frame_s n;

    // ----------------------------------------------------------------------
    // Bit sequencer
    // ----------------------------------------------------------------------
    // The line changes while the clock is low and is sampled as it rises.
    always_comb
    begin
        n      = r;
        n.done = 1'b0;
        unique case (r.st)
            mua_pkg::MUA_F_IDLE:
            begin
                if (start)
                begin
                    n.st    = mua_pkg::MUA_F_RUN;
                    n.div   = '0;
                    n.cnt   = '0;
                    n.mdc   = 1'b0;
                    n.oe_n  = 1'b0;
                    n.rd    = !is_write;
                    n.ack   = 1'b0;
                    n.rdata = '0;
                    n.sh    = {32'hFFFF_FFFF, 2'h1,
                               is_write ? 2'h1 : 2'h2, phy, regi,
                               is_write ? 2'h2 : 2'h3,
                               is_write ? wdata : 16'hFFFF};
                end
            end
            mua_pkg::MUA_F_RUN:
            begin
                if (r.div == DIV_END)
                begin
                    n.div = '0;
                    if (!r.mdc)
                    begin
                        n.mdc = 1'b1;
                        if (r.rd && r.cnt == mua_pkg::TA_SECOND)
                            n.ack = !mdio_in;
                        if (r.rd && r.cnt >= mua_pkg::DATA_FIRST)
                            n.rdata = {r.rdata[14:0], mdio_in};
                    end
                    else
                    begin
                        n.mdc = 1'b0;
                        if (r.cnt == mua_pkg::FRAME_LAST)
                        begin
                            n.st   = mua_pkg::MUA_F_IDLE;
                            n.done = 1'b1;
                            n.oe_n = 1'b1;
                        end
                        else
                        begin
                            n.cnt = r.cnt + 7'h1;
                            n.sh  = {r.sh[62:0], 1'b1};
                            if (r.rd && r.cnt + 7'h1 >= mua_pkg::TA_FIRST)
                                n.oe_n = 1'b1;
                        end
                    end
                end
                else
                begin
                    n.div = r.div + CW'(1);
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            r      <= '0;
            r.st   <= mua_pkg::MUA_F_IDLE;
            r.oe_n <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    assign busy      = (r.st == mua_pkg::MUA_F_RUN);
    assign done      = r.done;
    assign ack       = r.ack;
    assign rdata     = r.rdata;
    assign mdc       = r.mdc;
    assign mdio_o    = r.sh[63];
    assign mdio_oe_n = r.oe_n;
endmodule

// file: mua_phy_model.sv
// Behavioural PHY on the management link that answers the channel.
`timescale 1ns/10ps
module mua_phy_model (
    input  wire logic   mdc,
    input  wire logic   mdio,
    input  wire logic   ack_en,
    input  wire logic   link,
    output logic        mdio_drv,
    output logic [4:0]  wr_phy,
    output logic [4:0]  wr_reg,
    output logic [15:0] wr_data
);
    logic [5:0]  cnt = 6'h00;
    logic [62:0] sr = 63'h0;
    logic        rd_op = 1'b0;
    logic [15:0] rd_v = 16'h0000;
    logic [15:0] mem [32];
    logic [63:0] f;

    // Frames run back to back, so bit position is kept modulo 64.
    assign f = {sr, mdio};
    initial mdio_drv = 1'b1;
    always @(posedge mdc)
    begin
        sr <= f[62:0];
        cnt <= cnt + 6'h01;
        if (cnt == 6'h3F && f[31:28] == 4'h5)
        begin
            mem[f[22:18]] <= f[15:0];
            wr_phy <= f[27:23];
            wr_reg <= f[22:18];
            wr_data <= f[15:0];
        end
    end
    // Register 1 reports link in bit 2; unknown stays unknown elsewhere.
    always @(negedge mdc)
    begin
        if (cnt == 6'h2E)
        begin
            rd_op <= sr[13:10] == 4'h6 && ack_en;
            rd_v <= (sr[4:0] == 5'h01) ? {13'h0000, link, 2'h0}
                                       : mem[sr[4:0]];
        end
        if (rd_op && cnt == 6'h2F)
            mdio_drv <= 1'b0;
        else if (rd_op && cnt >= 6'h30)
            mdio_drv <= rd_v[6'h3F - cnt];
        else
            mdio_drv <= 1'b1;
    end
endmodule

// file: mua_pkg.sv
// Constants and types shared by the user access channel design files.
package mua_pkg;

    // ----------------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 5;
    localparam int MDC_HALF_NS       = 200;
    localparam int MDC_HALF_CYC      =
        (MDC_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    // ----------------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------------
    localparam int         ADDR_W       = 8;
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h08;
    localparam logic [7:0] ADDR_CMD     = 8'h0C;
    localparam logic [7:0] ADDR_SEL     = 8'h10;
    localparam logic [7:0] ADDR_LINK    = 8'h14;

    localparam int          CMD_GO_BIT   = 31;
    localparam int          CMD_WR_BIT   = 30;
    localparam int          CMD_ACK_BIT  = 29;
    localparam int          CMD_REG_LSB  = 21;
    localparam int          CMD_PHY_LSB  = 16;
    localparam logic [31:0] CMD_RW_MASK  = 32'h63FF_FFFF;
    localparam logic [31:0] CMD_RST      = 32'h0000_0000;

    localparam int         SEL_LINK_SOURCE_SELECT_BIT = 7;
    localparam int         SEL_INTEN_BIT   = 6;
    localparam int         SEL_MON_LSB     = 0;
    localparam logic [7:0] SEL_RW_MASK     = 8'hDF;
    localparam logic [7:0] SEL_RST         = 8'h00;

    localparam int         CTRL_EN_BIT = 0;
    localparam int         EVT_DONE    = 0;
    localparam int         EVT_LINK    = 1;
    localparam logic [1:0] EVT_RST     = 2'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------------
    // Management frame
    // ----------------------------------------------------------------------
    localparam logic [6:0] FRAME_LAST  = 7'h3F;
    localparam logic [6:0] TA_FIRST    = 7'h2E;
    localparam logic [6:0] TA_SECOND   = 7'h2F;
    localparam logic [6:0] DATA_FIRST  = 7'h30;
    localparam logic [4:0] PHY_STS_REG = 5'h01;
    localparam int         PHY_LINK_BIT = 2;

    typedef enum logic [2:0] {
        MUA_IDLE = 3'h1,
        MUA_USER = 3'h2,
        MUA_POLL = 3'h4
    } mua_state_e;

    typedef enum logic [1:0] {
        MUA_F_IDLE = 2'h1,
        MUA_F_RUN  = 2'h2
    } mua_fstate_e;

endpackage

// file: mua_props.sv
// Concurrent checks on the ports of the user access channel.
`timescale 1ns/10ps
module mua_props #(
    parameter int HALF_CYC = mua_pkg::MDC_HALF_CYC
) (
    input wire logic                       clk_sys,
    input wire logic                       rstn,
    input wire logic                       s_axi_awready,
    input wire logic                       s_axi_bvalid,
    input wire logic                       s_axi_bready,
    input wire logic                       s_axi_arready,
    input wire logic [mua_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic                       s_axi_rvalid,
    input wire logic                       s_axi_rready,
    input wire logic [31:0]                s_axi_rdata,
    input wire logic [1:0]                 s_axi_rresp,
    input wire logic                       mdc,
    input wire logic                       mdio_o,
    input wire logic                       mdio_oe_n
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    sequence s_cmd_rd;
        s_axi_arready && s_axi_araddr == mua_pkg::ADDR_CMD;
    endsequence
    sequence s_sel_rd;
        s_axi_arready && s_axi_araddr == mua_pkg::ADDR_SEL;
    endsequence
    property p_b_answer;
        s_axi_awready |=> s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer)
        else $error("write taken without a response");
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_done: assert property (p_b_done)
        else $error("write response repeated");
    property p_r_answer;
        s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer)
        else $error("read taken without data");
    property p_r_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_done: assert property (p_r_done)
        else $error("read data repeated");
    property p_cmd_rsvd;
        s_cmd_rd |=> s_axi_rdata[28:26] == 3'h0;
    endproperty
    a_cmd_rsvd: assert property (p_cmd_rsvd)
        else $error("command reserved bits not zero");
    property p_sel_rsvd;
        s_sel_rd |=> s_axi_rdata[31:8] == 24'h000000 && !s_axi_rdata[5];
    endproperty
    a_sel_rsvd: assert property (p_sel_rsvd)
        else $error("select reserved bits not zero");
    property p_unmapped;
        s_axi_arready && s_axi_araddr == 8'h18 |=>
            s_axi_rresp == mua_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");

    // ----------------------------------------------------------------
    // Management link
    // ----------------------------------------------------------------
    // The far side samples on the rise, so the line may only move low.
    property p_mdio_hold;
        mdc && $past(mdc) |-> $stable(mdio_o) && $stable(mdio_oe_n);
    endproperty
    a_mdio_hold: assert property (p_mdio_hold)
        else $error("data line moved while clock high");
endmodule

// file: mua_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/10ps
module mua_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mua_sync_s;

    mua_sync_s r;
    mua_sync_s n;

    always_comb
    begin
        n    = r;
        n.s1 = d;
        n.s2 = r.s1;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            r <= '0;
        else
            r <= n;
    end

    assign q = r.s2;
endmodule

// file: mua_top.sv
// User access channel one: register slave, command sequencing, link watch.
`timescale 1ns/10ps
module mua_top #(
    parameter int HALF_CYC = mua_pkg::MDC_HALF_CYC
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rstn,
    input  wire logic [mua_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic      [1:0]                 s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [mua_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic      [31:0]                s_axi_rdata,
    output logic      [1:0]                 s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic                            mdc,
    input  wire logic                       mdio_i,
    output logic                            mdio_o,
    output logic                            mdio_oe_n,
    output logic                            irq
);
    typedef struct packed {
        mua_pkg::mua_state_e st;
        logic                en;
        logic [31:0]         cmd;
        logic [7:0]          sel;
        logic                link;
        logic [1:0]          sts;
        logic [1:0]          msk;
        logic                irq;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [1:0]          rresp;
        logic [31:0]         rdata;
    } mua_top_s;

    mua_top_s r;
    mua_top_s n;

    logic        mdio_s;
    logic        f_start;
    logic        f_busy;
    logic        f_done;
    logic        f_ack;
    logic [15:0] f_rdata;
    logic        f_write;
    logic [4:0]  f_phy;
    logic [4:0]  f_reg;
    logic        wr_go;
    logic        rd_go;
    logic [7:0]  waddr;
    logic [7:0]  raddr;

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    function automatic logic [31:0] merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[8*i +: 8] = new_v[8*i +: 8];
        end
        return res;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == mua_pkg::ADDR_CTRL || a == mua_pkg::ADDR_IRQ_STS
            || a == mua_pkg::ADDR_IRQ_MSK || a == mua_pkg::ADDR_CMD
            || a == mua_pkg::ADDR_SEL || a == mua_pkg::ADDR_LINK;
    endfunction

    // ----------------------------------------------------------------------
    // Pins and frame engine
    // ----------------------------------------------------------------------
    mua_sync #(
        .W (1)
    ) u_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .d       (mdio_i),
        .q       (mdio_s)
    );

    // A poll of the watched PHY is only issued when no user command waits,
    // so software commands never queue behind more than one poll frame.
    assign f_start = (r.st == mua_pkg::MUA_IDLE) && r.en && !f_busy;
    assign f_write = r.cmd[mua_pkg::CMD_GO_BIT]
                   && r.cmd[mua_pkg::CMD_WR_BIT];
    assign f_phy   = r.cmd[mua_pkg::CMD_GO_BIT]
                   ? r.cmd[mua_pkg::CMD_PHY_LSB +: 5]
                   : r.sel[mua_pkg::SEL_MON_LSB +: 5];
    assign f_reg   = r.cmd[mua_pkg::CMD_GO_BIT]
                   ? r.cmd[mua_pkg::CMD_REG_LSB +: 5]
                   : mua_pkg::PHY_STS_REG;

    mua_frame #(
        .HALF_CYC (HALF_CYC)
    ) u_frame (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .start     (f_start),
        .is_write  (f_write),
        .phy       (f_phy),
        .regi      (f_reg),
        .wdata     (r.cmd[15:0]),
        .mdio_in   (mdio_s),
        .busy      (f_busy),
        .done      (f_done),
        .ack       (f_ack),
        .rdata     (f_rdata),
        .mdc       (mdc),
        .mdio_o    (mdio_o),
        .mdio_oe_n (mdio_oe_n)
    );

    // ----------------------------------------------------------------------
    // Bus handshakes
    // ----------------------------------------------------------------------
    // Address and data are taken together; the master offers both at once.
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !r.bvalid;
    assign rd_go = s_axi_arvalid && !r.rvalid;
    assign waddr = {s_axi_awaddr[7:2], 2'h0};
    assign raddr = {s_axi_araddr[7:2], 2'h0};

    // ----------------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------------
    always_comb
    begin
        logic [1:0]  evt;
        logic [1:0]  clr;
        logic [31:0] w;
        evt = 2'h0;
        clr = 2'h0;
        w   = '0;
        n   = r;

        unique case (r.st)
            mua_pkg::MUA_IDLE:
            begin
                if (f_start)
                    n.st = r.cmd[mua_pkg::CMD_GO_BIT]
                         ? mua_pkg::MUA_USER : mua_pkg::MUA_POLL;
            end
            mua_pkg::MUA_USER:
            begin
                if (f_done)
                begin
                    n.st = mua_pkg::MUA_IDLE;
                    if (!r.cmd[mua_pkg::CMD_WR_BIT])
                    begin
                        n.cmd[15:0] = f_rdata;
                        n.cmd[mua_pkg::CMD_ACK_BIT] = f_ack;
                    end
                    n.cmd[mua_pkg::CMD_GO_BIT] = 1'b0;
                    evt[mua_pkg::EVT_DONE] = 1'b1;
                end
            end
            mua_pkg::MUA_POLL:
            begin
                if (f_done)
                begin
                    n.st = mua_pkg::MUA_IDLE;
                    if (f_ack && f_rdata[mua_pkg::PHY_LINK_BIT] != r.link)
                    begin
                        n.link = f_rdata[mua_pkg::PHY_LINK_BIT];
                        evt[mua_pkg::EVT_LINK] =
                            r.sel[mua_pkg::SEL_INTEN_BIT];
                    end
                end
            end
        endcase

        if (wr_go)
        begin
            n.bvalid = 1'b1;
            n.bresp  = mapped(waddr) ? mua_pkg::RESP_OKAY
                                     : mua_pkg::RESP_SLVERR;
            unique case (waddr)
                mua_pkg::ADDR_CTRL:
                    if (s_axi_wstrb[0])
                        n.en = s_axi_wdata[mua_pkg::CTRL_EN_BIT];
                mua_pkg::ADDR_IRQ_STS:
                    if (s_axi_wstrb[0])
                        clr = s_axi_wdata[1:0];
                mua_pkg::ADDR_IRQ_MSK:
                    if (s_axi_wstrb[0])
                        n.msk = s_axi_wdata[1:0];
                mua_pkg::ADDR_CMD:
                begin
                    if (!r.cmd[mua_pkg::CMD_GO_BIT])
                    begin
                        w     = merge(r.cmd, s_axi_wdata, s_axi_wstrb);
                        n.cmd = w & mua_pkg::CMD_RW_MASK;
                        n.cmd[mua_pkg::CMD_GO_BIT] =
                            w[mua_pkg::CMD_GO_BIT] && r.en;
                    end
                end
                mua_pkg::ADDR_SEL:
                    if (s_axi_wstrb[0])
                        n.sel = s_axi_wdata[7:0]
                              & mua_pkg::SEL_RW_MASK;
                default:
                begin
                end
            endcase
        end
        else if (r.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
        end

        if (rd_go)
        begin
            n.rvalid = 1'b1;
            n.rresp  = mapped(raddr) ? mua_pkg::RESP_OKAY
                                     : mua_pkg::RESP_SLVERR;
            unique case (raddr)
                mua_pkg::ADDR_CTRL:    n.rdata = {31'h0, r.en};
                mua_pkg::ADDR_IRQ_STS: n.rdata = {30'h0, r.sts};
                mua_pkg::ADDR_IRQ_MSK: n.rdata = {30'h0, r.msk};
                mua_pkg::ADDR_CMD:     n.rdata = r.cmd;
                mua_pkg::ADDR_SEL:     n.rdata = {24'h0, r.sel};
                mua_pkg::ADDR_LINK:    n.rdata = {31'h0, r.link};
                default:               n.rdata = 32'h0000_0000;
            endcase
        end
        else if (r.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
        end

        // A new event wins over a clear written in the same cycle.
        n.sts = (r.sts & ~clr) | evt;
        n.irq = |(n.sts & n.msk);
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            r     <= '0;
            r.st  <= mua_pkg::MUA_IDLE;
            r.cmd <= mua_pkg::CMD_RST;
            r.sel <= mua_pkg::SEL_RST;
            r.sts <= mua_pkg::EVT_RST;
        end
        else
        begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------------
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = rd_go;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rresp   = r.rresp;
    assign s_axi_rdata   = r.rdata;
    assign irq           = r.irq;
endmodule

// file: mua_top_tb.sv
// Register-level testbench of the user access channel.
`timescale 1ns/10ps
module mua_top_tb;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1;
    logic        s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, mdc, mdio_o, mdio_oe_n;
    logic [1:0]  s_axi_bresp, s_axi_rresp, bq;
    logic [31:0] s_axi_rdata, v;
    logic        irq, phy_drv, ack_en = 1'b1, link = 1'b0;
    logic [4:0]  wr_phy, wr_reg;
    logic [15:0] wr_data;
    int          err_count = 0;
    int          comparisons = 0;
    wire logic   mdio_i = mdio_oe_n ? phy_drv : mdio_o;

    always #2.5 clk_sys = ~clk_sys;
    mua_top #(.HALF_CYC(4)) u_mua_top (.clk_sys, .rstn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mdc,
        .mdio_i, .mdio_o, .mdio_oe_n, .irq);
    mua_phy_model u_mua_phy_model (.mdc, .mdio(mdio_i), .ack_en, .link,
        .mdio_drv(phy_drv), .wr_phy, .wr_reg, .wr_data);

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Ready is sampled mid-cycle, where it is settled until the edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(negedge clk_sys); while (!s_axi_awready);
        @(posedge clk_sys);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(negedge clk_sys); while (!s_axi_bvalid);
        bq = s_axi_bresp;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge clk_sys); while (!s_axi_arready);
        @(posedge clk_sys);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk_sys); while (!s_axi_rvalid);
        d = s_axi_rdata;
        @(posedge clk_sys);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a, v);
        chk(v, e);
    endtask
    task automatic wait_go;
        do rd(mua_pkg::ADDR_CMD, v); while (v[31] !== 1'b0);
    endtask
    task automatic complete_run;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rchk(mua_pkg::ADDR_CMD, 32'h0);
        rchk(mua_pkg::ADDR_SEL, 32'h0);
        rchk(8'h18, 32'h0);
        wr(8'h18, 32'h1);
        chk({30'h0, bq}, {30'h0, mua_pkg::RESP_SLVERR});
        wr(mua_pkg::ADDR_CMD, 32'h9C00_1234);
        rchk(mua_pkg::ADDR_CMD, 32'h0000_1234);
        $display("test reset and disabled start finished");
        wr(mua_pkg::ADDR_CTRL, 32'h1);
        wr(mua_pkg::ADDR_CMD, 32'hC27E_A5C3);
        wr(mua_pkg::ADDR_CMD, 32'h0);
        chk({30'h0, bq}, {30'h0, mua_pkg::RESP_OKAY});
        rchk(mua_pkg::ADDR_CMD, 32'hC27E_A5C3);
        wait_go();
        chk(v, 32'h427E_A5C3);
        chk({6'h0, wr_phy, wr_reg, wr_data}, 32'h03D3_A5C3);
        $display("test phy write finished");
        wr(mua_pkg::ADDR_CMD, 32'h827E_0000);
        wait_go();
        chk(v, 32'h227E_A5C3);
        ack_en <= 1'b0;
        wr(mua_pkg::ADDR_CMD, 32'h80FE_0000);
        wait_go();
        chk({29'h0, v[31:29]}, 32'h0);
        ack_en <= 1'b1;
        $display("test phy read finished");
        wr(mua_pkg::ADDR_IRQ_STS, 32'h3);
        rchk(mua_pkg::ADDR_IRQ_STS, 32'h0);
        wr(mua_pkg::ADDR_IRQ_MSK, 32'h3);
        wr(mua_pkg::ADDR_SEL, 32'hFFFF_FF62);
        rchk(mua_pkg::ADDR_SEL, 32'h42);
        link <= 1'b1;
        for (int n = 0; n < 3000 && irq !== 1'b1; n++)
            @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        rchk(mua_pkg::ADDR_IRQ_STS, 32'h2);
        rchk(mua_pkg::ADDR_LINK, 32'h1);
        wr(mua_pkg::ADDR_IRQ_MSK, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        wr(mua_pkg::ADDR_IRQ_STS, 32'h2);
        rchk(mua_pkg::ADDR_IRQ_STS, 32'h0);
        wr(mua_pkg::ADDR_SEL, 32'h02);
        link <= 1'b0;
        repeat (1500) @(posedge clk_sys);
        rchk(mua_pkg::ADDR_IRQ_STS, 32'h0);
        rchk(mua_pkg::ADDR_LINK, 32'h0);
        $display("test link interrupt finished");
        complete_run();
    end
    // Whole run is near 5100 cycles; about eight times that means a hang.
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        err_count++;
        complete_run();
    end
endmodule

bind mua_top mua_props #(.HALF_CYC(HALF_CYC)) u_mua_props (.clk_sys, .rstn,
    .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .mdc, .mdio_o, .mdio_oe_n);
